// ==== hdl/mrs_pkg.sv ====
// Constants shared by the serial slave message handler and its check engine.
// Assumes byte framing, frame-end detection and the register store sit outside.
package mrs_pkg;
  // Function codes
  localparam logic [7:0]  MRS_FN_READ    = 8'h03;
  localparam logic [7:0]  MRS_FN_WRITE1  = 8'h06;
  localparam logic [7:0]  MRS_FN_DIAG    = 8'h08;
  localparam logic [7:0]  MRS_FN_ERRBIT  = 8'h80;
  localparam logic [7:0]  MRS_BCAST_ADDR = 8'h00;
  // Exception codes carried by error responses
  localparam logic [7:0]  MRS_EX_FUNC    = 8'h01;
  localparam logic [7:0]  MRS_EX_ADDR    = 8'h02;
  localparam logic [7:0]  MRS_EX_VALUE   = 8'h03;
  // Holding register number of field value zero (40001 decimal)
  localparam logic [16:0] MRS_MAP_BASE   = 17'h09C41;
  localparam logic [7:0]  MRS_MAX_READ   = 8'h7D;
  // Frame layout
  localparam logic [3:0]  MRS_FIX_LEN    = 4'h8;
  localparam logic [3:0]  MRS_MIN_LEN    = 4'h4;
  localparam logic [7:0]  MRS_RD_HDR     = 8'h03;
  localparam logic [7:0]  MRS_RD_OVH     = 8'h05;
  localparam logic [7:0]  MRS_ERR_LEN    = 8'h05;
  localparam logic [7:0]  MRS_CRC_LEN    = 8'h02;
  // Check sum engine
  localparam logic [15:0] MRS_CRC_POLY   = 16'hA001;
  localparam logic [15:0] MRS_CRC_INIT   = 16'hFFFF;
  // Region codes reported by the register store
  localparam logic [1:0]  MRS_RG_SYSVAR  = 2'h0;
  localparam logic [1:0]  MRS_RG_MONITOR = 2'h1;
  localparam logic [1:0]  MRS_RG_FAULT   = 2'h2;
  localparam logic [1:0]  MRS_RG_PARAM   = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_DECODE = 3'h1,
    ST_WRCHK  = 3'h3,
    ST_LOAD   = 3'h2,
    ST_HOLD   = 3'h6,
    ST_FETCH  = 3'h7,
    ST_WAIT   = 3'h5,
    ST_GRAB   = 3'h4
  } mrs_state_e;

  typedef enum logic [1:0] {
    MD_ECHO = 2'h0,
    MD_READ = 2'h1,
    MD_ERR  = 2'h2
  } mrs_mode_e;
endpackage

// ==== hdl/mrs_crc_if.sv ====
// Connection between the message handler and one check sum engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface mrs_crc_if;
  logic        clr;
  logic        en;
  logic [7:0]  data;
  logic [15:0] crc;
  modport host   (output clr, output en, output data, input crc);
  modport engine (input clr, input en, input data, output crc);
endinterface

// ==== hdl/mrs_crc16.sv ====
// Byte-wide reflected CRC-16 engine, one byte per clock.
// Assumes clr and en come from logic on the same clock; clr wins over en.
`timescale 1ns/1ns
module mrs_crc16 #(
  parameter logic [15:0] POLY = mrs_pkg::MRS_CRC_POLY,
  parameter logic [15:0] INIT = mrs_pkg::MRS_CRC_INIT
) (
  input wire logic    sys_clk,
  input wire logic    reset,
  mrs_crc_if.engine   port
);
  logic [15:0] next_crc;
  logic [15:0] c;

  // Eight shift steps per byte, low bit first
  always_comb begin
    c = port.crc ^ {8'h00, port.data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ POLY) : (c >> 1);
    end
    if (port.clr) begin
      next_crc = INIT;
    end else if (port.en) begin
      next_crc = c;
    end else begin
      next_crc = port.crc;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      port.crc <= INIT;
    end else begin
      port.crc <= next_crc;
    end
  end
endmodule

// ==== hdl/mrs_slave.sv ====
// Slave message handler: decodes read, single write and loopback queries
// and streams the answer frame. Assumes bytes, frame end, transmit ready
// and the register store all come from logic on sys_clk.
//
// Behaviour
// - Read query: address, function 03, start and count high first, check sum.
// - Start field plus 40001 gives the holding register number.
// - Read counts above 125 are not served.
// - Read answer byte count is twice the register count.
// - Register words go high byte first, ascending from the start.
// - Address 0 is invalid for read and loopback queries.
// - Single write query: function 06, address and two data bytes, high first.
// - Write register number is address field plus 40001.
// - Single write to address 0 is executed as broadcast.
// - No answer at all to a broadcast single write.
// - Addressed single write is answered with an exact copy.
// - Loopback query: function 08, subfunction 0000, any two data bytes.
// - Loopback query is returned unchanged, check sum included.
// - Writes only reach system variable and parameter regions.
// - Reads reach all four register regions.
// - Check sum closes each frame, low byte first.
// - Error answer function byte is the query function plus 80.
// - Unsupported function gets an error answer.
`timescale 1ns/1ns
module mrs_slave #(
  parameter logic [7:0] MAX_READ = mrs_pkg::MRS_MAX_READ
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  my_addr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_end,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [16:0]      reg_num,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rd_data,
  input  wire logic        reg_hit,
  input  wire logic [1:0]  reg_region
);
  mrs_pkg::mrs_state_e st, next_st;
  mrs_pkg::mrs_mode_e  mode, next_mode;
  logic [7:0]  frm [0:7];
  logic [7:0]  next_frm [0:7];
  logic [3:0]  cnt, next_cnt;
  logic        crc_ok, next_crc_ok;
  logic [7:0]  tx_idx, next_tx_idx;
  logic [7:0]  tx_len, next_tx_len;
  logic [7:0]  err_code, next_err_code;
  logic [15:0] word, next_word;
  logic [6:0]  word_num, next_word_num;
  logic        next_tx_valid, next_reg_rd, next_reg_wr;
  logic [7:0]  next_tx_data;
  logic [16:0] next_reg_num;
  logic [15:0] next_reg_wdata;
  logic        bcast, good, wr_ok, at_crc, fetch_next;
  logic [7:0]  idx_inc, crc_pos;

  mrs_crc_if crc_rx ();
  mrs_crc_if crc_tx ();
  mrs_crc16 u_crc_rx (.sys_clk(sys_clk), .reset(reset), .port(crc_rx));
  mrs_crc16 u_crc_tx (.sys_clk(sys_clk), .reset(reset), .port(crc_tx));

  // Frame qualifiers; the frame buffer is frozen outside idle
  assign bcast   = (frm[0] == mrs_pkg::MRS_BCAST_ADDR);
  assign good    = crc_ok && (bcast || frm[0] == my_addr) && (cnt >= mrs_pkg::MRS_MIN_LEN);
  assign wr_ok   = reg_hit && (reg_region == mrs_pkg::MRS_RG_SYSVAR ||
                               reg_region == mrs_pkg::MRS_RG_PARAM);
  assign crc_pos = 8'(tx_len - mrs_pkg::MRS_CRC_LEN);
  assign at_crc  = (mode != mrs_pkg::MD_ECHO) && (tx_idx >= crc_pos);
  assign idx_inc = 8'(tx_idx + 8'h01);
  // A fresh word is fetched before each high data byte
  assign fetch_next = (mode == mrs_pkg::MD_READ) && idx_inc[0] &&
                      (idx_inc >= mrs_pkg::MRS_RD_HDR) && (idx_inc < crc_pos);

  // Check sums over received bytes and over generated answers
  assign crc_rx.clr  = (st == mrs_pkg::ST_DECODE);
  assign crc_rx.en   = (st == mrs_pkg::ST_IDLE) && rx_valid;
  assign crc_rx.data = rx_data;
  assign crc_tx.clr  = (st == mrs_pkg::ST_DECODE);
  assign crc_tx.en   = (st == mrs_pkg::ST_LOAD) && !at_crc && (mode != mrs_pkg::MD_ECHO);
  assign crc_tx.data = next_tx_data;

  // Next-state logic for receive, decode and transmit
  always_comb begin
    next_st        = st;
    next_mode      = mode;
    next_frm       = frm;
    next_cnt       = cnt;
    next_crc_ok    = crc_ok;
    next_tx_idx    = tx_idx;
    next_tx_len    = tx_len;
    next_err_code  = err_code;
    next_word      = word;
    next_word_num  = word_num;
    next_tx_valid  = tx_valid;
    next_tx_data   = tx_data;
    next_reg_rd    = 1'b0;
    next_reg_wr    = 1'b0;
    next_reg_num   = reg_num;
    next_reg_wdata = reg_wdata;
    unique case (st)
      mrs_pkg::ST_IDLE: begin
        // Bytes past eight are not stored and the count stops at nine, so long frames fail the length test
        if (rx_valid) begin
          if (cnt < mrs_pkg::MRS_FIX_LEN) begin
            next_frm[cnt[2:0]] = rx_data;
          end
          if (cnt <= mrs_pkg::MRS_FIX_LEN) begin
            next_cnt = 4'(cnt + 4'h1);
          end
        end else if (rx_end) begin
          // Residue of zero means the trailing check sum matched
          next_crc_ok = (crc_rx.crc == 16'h0000);
          next_st     = mrs_pkg::ST_DECODE;
        end
      end
      mrs_pkg::ST_DECODE: begin
        next_cnt      = 4'h0;
        next_tx_idx   = 8'h00;
        next_word_num = 7'h00;
        next_st       = mrs_pkg::ST_IDLE;
        next_tx_len   = mrs_pkg::MRS_ERR_LEN;
        next_mode     = mrs_pkg::MD_ERR;
        // Bad check sum or foreign address: drop
        if (good) begin
          // Write query: map address, then test region
          if (frm[1] == mrs_pkg::MRS_FN_WRITE1) begin
            if (cnt == mrs_pkg::MRS_FIX_LEN) begin
              next_reg_num   = 17'({1'b0, frm[2], frm[3]}) + mrs_pkg::MRS_MAP_BASE;
              next_reg_wdata = {frm[4], frm[5]};
              next_st        = mrs_pkg::ST_WRCHK;
            end
          // Broadcast is invalid for every other function
          end else if (!bcast) begin
            if (frm[1] == mrs_pkg::MRS_FN_READ) begin
              // Count must be 1 to the limit
              if (cnt == mrs_pkg::MRS_FIX_LEN) begin
                next_st = mrs_pkg::ST_LOAD;
                if (frm[4] == 8'h00 && frm[5] != 8'h00 && frm[5] <= MAX_READ) begin
                  next_mode   = mrs_pkg::MD_READ;
                  next_tx_len = 8'(mrs_pkg::MRS_RD_OVH + {frm[5][6:0], 1'b0});
                end else begin
                  next_err_code = mrs_pkg::MRS_EX_VALUE;
                end
              end
            end else if (frm[1] == mrs_pkg::MRS_FN_DIAG) begin
              // Subfunction zero loops back, others are refused
              if (cnt == mrs_pkg::MRS_FIX_LEN) begin
                next_st = mrs_pkg::ST_LOAD;
                if ({frm[2], frm[3]} == 16'h0000) begin
                  next_mode   = mrs_pkg::MD_ECHO;
                  next_tx_len = 8'({4'h0, mrs_pkg::MRS_FIX_LEN});
                end else begin
                  next_err_code = mrs_pkg::MRS_EX_FUNC;
                end
              end
            end else begin
              next_err_code = mrs_pkg::MRS_EX_FUNC;
              next_st       = mrs_pkg::ST_LOAD;
            end
          end
        end
      end
      mrs_pkg::ST_WRCHK: begin
        // Broadcast writes execute too; but stay silent
        next_reg_wr   = wr_ok;
        next_st       = bcast ? mrs_pkg::ST_IDLE : mrs_pkg::ST_LOAD;
        next_err_code = mrs_pkg::MRS_EX_ADDR;
        if (wr_ok) begin
          next_mode   = mrs_pkg::MD_ECHO;
          next_tx_len = 8'({4'h0, mrs_pkg::MRS_FIX_LEN});
        end
      end
      mrs_pkg::ST_LOAD: begin
        next_tx_valid = 1'b1;
        if (mode == mrs_pkg::MD_ECHO) begin
          next_tx_data = frm[tx_idx[2:0]];
        end else if (at_crc) begin
          next_tx_data = (tx_idx == crc_pos) ? crc_tx.crc[7:0] : crc_tx.crc[15:8];
        end else if (tx_idx == 8'h00) begin
          next_tx_data = frm[0];
        end else if (tx_idx == 8'h01) begin
          // Error answers flag the function byte
          next_tx_data = (mode == mrs_pkg::MD_ERR) ? (frm[1] | mrs_pkg::MRS_FN_ERRBIT) : frm[1];
        end else if (tx_idx == 8'h02) begin
          next_tx_data = (mode == mrs_pkg::MD_ERR) ? err_code : {frm[5][6:0], 1'b0};
        end else begin
          // High byte on odd index, low byte on even
          next_tx_data = tx_idx[0] ? word[15:8] : word[7:0];
        end
        next_st = mrs_pkg::ST_HOLD;
      end
      mrs_pkg::ST_HOLD: begin
        if (tx_ready) begin
          next_tx_valid = 1'b0;
          next_tx_idx   = idx_inc;
          if (idx_inc == tx_len) begin
            next_st = mrs_pkg::ST_IDLE;
          end else if (fetch_next) begin
            next_st = mrs_pkg::ST_FETCH;
          end else begin
            next_st = mrs_pkg::ST_LOAD;
          end
        end
      end
      mrs_pkg::ST_FETCH: begin
        // Any region may be read, ascending from the start
        next_reg_num = 17'({1'b0, frm[2], frm[3]}) + mrs_pkg::MRS_MAP_BASE +
                       {10'h000, word_num};
        next_reg_rd  = 1'b1;
        next_st      = mrs_pkg::ST_WAIT;
      end
      mrs_pkg::ST_WAIT: begin
        next_st = mrs_pkg::ST_GRAB;
      end
      mrs_pkg::ST_GRAB: begin
        next_word     = reg_rd_data;
        next_word_num = 7'(word_num + 7'h01);
        next_st       = mrs_pkg::ST_LOAD;
      end
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st        <= mrs_pkg::ST_IDLE;
      mode      <= mrs_pkg::MD_ECHO;
      frm       <= '{default: 8'h00};
      cnt       <= 4'h0;
      crc_ok    <= 1'b0;
      tx_idx    <= 8'h00;
      tx_len    <= 8'h00;
      err_code  <= 8'h00;
      word      <= 16'h0000;
      word_num  <= 7'h00;
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
      reg_rd    <= 1'b0;
      reg_wr    <= 1'b0;
      reg_num   <= 17'h00000;
      reg_wdata <= 16'h0000;
    end else begin
      st        <= next_st;
      mode      <= next_mode;
      frm       <= next_frm;
      cnt       <= next_cnt;
      crc_ok    <= next_crc_ok;
      tx_idx    <= next_tx_idx;
      tx_len    <= next_tx_len;
      err_code  <= next_err_code;
      word      <= next_word;
      word_num  <= next_word_num;
      tx_valid  <= next_tx_valid;
      tx_data   <= next_tx_data;
      reg_rd    <= next_reg_rd;
      reg_wr    <= next_reg_wr;
      reg_num   <= next_reg_num;
      reg_wdata <= next_reg_wdata;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_wr_query;
    st == mrs_pkg::ST_DECODE && good && frm[1] == mrs_pkg::MRS_FN_WRITE1 &&
    cnt == mrs_pkg::MRS_FIX_LEN;
  endsequence
  sequence s_wr_allowed;
    wr_ok;
  endsequence

  crc_drop_a: assert property (st == mrs_pkg::ST_DECODE && !crc_ok |=>
    st == mrs_pkg::ST_IDLE && !tx_valid) else $error("bad frame not dropped");
  bcast_silent_a: assert property (st == mrs_pkg::ST_DECODE && bcast |->
    !tx_valid [*4]) else $error("answer to broadcast");
  bcast_write_a: assert property (s_wr_query ##1 s_wr_allowed |=> reg_wr)
    else $error("write not executed");
  wr_region_a: assert property (reg_wr |->
    $past(reg_region) != mrs_pkg::MRS_RG_MONITOR &&
    $past(reg_region) != mrs_pkg::MRS_RG_FAULT) else $error("write to read-only region");
  no_bcast_rd_a: assert property (st == mrs_pkg::ST_DECODE && bcast &&
    frm[1] != mrs_pkg::MRS_FN_WRITE1 |=> st == mrs_pkg::ST_IDLE) else $error("broadcast served");
  err_func_a: assert property (tx_valid && mode == mrs_pkg::MD_ERR && tx_idx == 8'h01 |->
    tx_data == (frm[1] | 8'h80)) else $error("error function byte wrong");
  byte_count_a: assert property (tx_valid && mode == mrs_pkg::MD_READ &&
    tx_idx == 8'h02 |-> tx_data == 8'(2 * frm[5])) else $error("byte count wrong");
  echo_copy_a: assert property (tx_valid && mode == mrs_pkg::MD_ECHO |->
    tx_data == frm[tx_idx[2:0]]) else $error("echo byte differs");
  reg_map_a: assert property ($rose(reg_rd) |-> reg_num ==
    17'({frm[2], frm[3]}) + 17'h09C41 + 17'($past(word_num))) else $error("register map wrong");
  read_order_a: assert property (st == mrs_pkg::ST_GRAB ##1 st == mrs_pkg::ST_LOAD ##1
    tx_valid |-> tx_data == word[15:8]) else $error("high byte not first");
endmodule

// ==== verif/mrs_store_model.sv ====
// Holding register store facing the slave handler: four regions, read data one cycle late.
// Assumes reg_rd and reg_wr are one-cycle pulses from logic on sys_clk.
`timescale 1ns/1ns
module mrs_store_model (
  input  wire logic        sys_clk,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [16:0] reg_num,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rd_data,
  output logic             reg_hit,
  output logic [1:0]       reg_region,
  output int               wr_count,
  output logic [16:0]      wr_num,
  output logic [15:0]      wr_data
);
  // region map
  // Bases 40001, 40100, 40200, 41000; numbers from 43000 up do not exist
  always_comb begin
    reg_hit = (reg_num >= 17'h09C41) && (reg_num < 17'h0A7F8);
    if (reg_num >= 17'h0A028) reg_region = 2'h3;
    else if (reg_num >= 17'h09D08) reg_region = 2'h2;
    else if (reg_num >= 17'h09CA4) reg_region = 2'h1;
    else reg_region = 2'h0;
  end

  // Data is only good the cycle after a read; otherwise it toggles so stale use shows
  always @(posedge sys_clk) begin
    if (reg_rd) reg_rd_data <= reg_num[15:0] ^ 16'hA55A;
    else reg_rd_data <= ~reg_rd_data;
    if (reg_wr) begin
      wr_count <= wr_count + 1;
      wr_num   <= reg_num;
      wr_data  <= reg_wdata;
    end
  end

  initial begin
    wr_count    = 0;
    reg_rd_data = 16'h0000;
  end
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the slave handler; the bench plays the master.
// Assumes the store model answers the register port.
`timescale 1ns/1ns
module tb;
  typedef logic [7:0] mrs_bq_t [$];
  logic        sys_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        rx_valid = 1'b0;
  logic        rx_end   = 1'b0;
  logic        tx_ready = 1'b0;
  logic [7:0]  my_addr  = 8'h11;
  logic [7:0]  rx_data  = 8'h00;
  logic [1:0]  rdy_cnt  = 2'h0;
  logic        tx_valid, reg_rd, reg_wr, reg_hit;
  logic [7:0]  tx_data;
  logic [16:0] reg_num, wr_num;
  logic [15:0] reg_wdata, reg_rd_data, wr_data;
  logic [1:0]  reg_region;
  int          failures  = 0;
  int          cmp_count = 0;
  int          wr_count;
  mrs_bq_t     none;

  always #2 sys_clk = ~sys_clk;

  // Sink stalls one cycle in four so held bytes are exercised
  always @(posedge sys_clk) begin
    rdy_cnt  <= rdy_cnt + 2'h1;
    tx_ready <= (rdy_cnt != 2'h3);
  end

  mrs_slave DUT (.sys_clk(sys_clk), .reset(reset), .my_addr(my_addr), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_num(reg_num),
    .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .reg_hit(reg_hit),
    .reg_region(reg_region));
  mrs_store_model store (.sys_clk(sys_clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .reg_hit(reg_hit),
    .reg_region(reg_region), .wr_count(wr_count), .wr_num(wr_num), .wr_data(wr_data));

  // Reference check sum, bit-serial so it shares nothing with the engine
  function automatic logic [15:0] crc16(mrs_bq_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  // Check sum appended low byte first
  function automatic mrs_bq_t seal(mrs_bq_t q);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction

  task automatic stop_test();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic chk_frame(input mrs_bq_t got, input mrs_bq_t exp, input string what);
    bit bad;
    bad = (got.size() != exp.size());
    cmp_count++;
    if (!bad) foreach (exp[i]) if (got[i] !== exp[i]) bad = 1'b1;
    if (bad) begin
      failures++;
      $display("Error t=%0t %s frame mismatch, %0d bytes", $time, what, got.size());
    end
  endtask

  task automatic set_addr(input logic [7:0] a);
    @(posedge sys_clk) my_addr <= a;
    @(posedge sys_clk);
  endtask

  // One byte per cycle, then the end pulse one cycle after the last byte
  task automatic xfer(input mrs_bq_t q, output mrs_bq_t r);
    int idle;
    foreach (q[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data  <= q[i];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_end   <= 1'b1;
    @(posedge sys_clk) rx_end <= 1'b0;
    // quiet gap doubles as processing time before the next query
    r = {};
    idle = 0;
    while (idle < 24) begin
      @(posedge sys_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        r.push_back(tx_data);
        idle = 0;
      end
      else idle++;
    end
  endtask

  task automatic do_read(input logic [15:0] start, input logic [15:0] cnt);
    mrs_bq_t     q, e, r;
    logic [15:0] d;
    q = seal('{8'h11, 8'h03, start[15:8], start[7:0], cnt[15:8], cnt[7:0]});
    e = '{8'h11, 8'h03, 8'(cnt * 2)};
    for (int k = 0; k < cnt; k++) begin
      d = 16'(start + 16'(k) + 16'h9C41) ^ 16'hA55A;
      e.push_back(d[15:8]);
      e.push_back(d[7:0]);
    end
    if (cnt == 16'h0000 || cnt > 16'h007D) e = '{8'h11, 8'h83, 8'h03};
    xfer(q, r);
    chk_frame(r, seal(e), "read answer");
  endtask

  task automatic do_write(input logic [7:0] a, input logic [15:0] f, input logic [15:0] v,
                          input bit refused);
    mrs_bq_t q, r;
    int      n0;
    q = seal('{a, 8'h06, f[15:8], f[7:0], v[15:8], v[7:0]});
    n0 = wr_count;
    xfer(q, r);
    if (a == 8'h00) chk_frame(r, none, "broadcast answer");
    else if (refused) chk_frame(r, seal('{a, 8'h86, 8'h02}), "refused write");
    else chk_frame(r, q, "write echo");
    chk(wr_count - n0, refused ? 0 : 1, "write count");
    if (!refused) chk(wr_num, 17'(f) + 17'h09C41, "write number");
    if (!refused) chk(wr_data, v, "write data");
  endtask

  task automatic t_read();
    chk(crc16('{8'h11, 8'h03, 8'h03, 8'hEB, 8'h00, 8'h03}), 16'h2B77, "ref crc");
    do_read(16'h03EB, 16'h0003);
    do_read(16'h0063, 16'h0002);
    do_read(16'h00C7, 16'h0001);
    do_read(16'h0000, 16'h007D);
    do_read(16'h0000, 16'h007E);
    // Zero count and a nonzero high count byte are both refused
    do_read(16'h0000, 16'h0000);
    do_read(16'h0000, 16'h0101);
  endtask

  task automatic t_write();
    set_addr(8'h05);
    do_write(8'h05, 16'h000D, 16'h1770, 1'b0);
    do_write(8'h00, 16'h03E8, 16'h1234, 1'b0);
    do_write(8'h05, 16'h0063, 16'hBEEF, 1'b1);
    do_write(8'h05, 16'h00C7, 16'hBEEF, 1'b1);
    set_addr(8'h11);
  endtask

  task automatic t_refuse();
    mrs_bq_t q, r;
    int      n0;
    xfer(seal('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}), r);
    chk_frame(r, none, "broadcast read");
    xfer(seal('{8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}), r);
    chk_frame(r, none, "broadcast loopback");
    // A query for another slave on the line must stay unanswered
    xfer(seal('{8'h22, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}), r);
    chk_frame(r, none, "foreign address");
    // Corrupt only the check sum high byte of a valid write
    q = seal('{8'h11, 8'h06, 8'h00, 8'h00, 8'h55, 8'h55});
    q[7] = q[7] ^ 8'h01;
    n0 = wr_count;
    xfer(q, r);
    chk_frame(r, none, "bad check sum");
    chk(wr_count - n0, 0, "bad check sum write");
  endtask

  task automatic t_diag();
    mrs_bq_t     q, r;
    logic [15:0] dd [3] = '{16'h0000, 16'hFFFF, 16'h5AA5};
    foreach (dd[i]) begin
      q = seal('{8'h11, 8'h08, 8'h00, 8'h00, dd[i][15:8], dd[i][7:0]});
      xfer(q, r);
      chk_frame(r, q, "loopback");
    end
    // Only subfunction zero loops back; any other is refused
    xfer(seal('{8'h11, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00}), r);
    chk_frame(r, seal('{8'h11, 8'h88, 8'h01}), "bad subfunction");
    xfer(seal('{8'h11, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00}), r);
    chk_frame(r, seal('{8'h11, 8'h87, 8'h01}), "bad function");
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (50000) @(posedge sys_clk);
    failures++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_read();
    t_write();
    t_refuse();
    t_diag();
    stop_test();
  end
endmodule
